/* include/uart_ctl_pkg.sv */
// Shared constants, register layouts and types for the serial control block
// Notes on behaviour
// - Transmit-empty enable gates buffer-empty flag onto interrupt
// - Transmit-done enable gates done flag onto interrupt
// - Receive enable gates buffer-full flag onto interrupt
// - Quiet-line enable gates idle flag onto interrupt
// - Transmitter runs and owns pin while enabled
// - Single-wire mode: direction bit steers shared pin
// - Enable off-then-on queues one idle character
// - Pin held until pending idle, break, data finish
// - Receiver off releases receive pin to port
// - Loopback always releases the receive pin
// - Standby set by write, cleared by wakeup
// - Wakeup: idle line, or data MSB high
// - Break bit one then zero sends one break
// - Breaks repeat while set; 10/11, long 13/14
// - Either one or two breaks may result
// - Control register accessible at any time
// - Status register read-only, writes ignored
// - Done flag set at reset and when idle
// - Loopback source picks internal loop or single-wire
package uart_ctl_pkg;

    localparam int ADDR_W = 8;

    // Register byte addresses on the bus
    localparam logic [ADDR_W-1:0] ADDR_CONTROL_TWO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_ONE  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_MODE        = 8'h08;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'h0;

    // Second control register, MSB first
    typedef struct packed {
        logic tx_empty_irq_on;
        logic tx_done_irq_on;
        logic rx_full_irq_on;
        logic quiet_line_irq_on;
        logic tx_on;
        logic rx_on;
        logic rx_standby;
        logic break_queue;
    } control_two_t;

    // First status register, MSB first
    typedef struct packed {
        logic tx_buffer_empty;
        logic tx_done;
        logic rx_buffer_full;
        logic idle;
        logic overrun;
        logic noise;
        logic framing;
        logic parity_err;
    } status_one_t;

    // Receiver-side flags supplied by the receive datapath
    typedef struct packed {
        logic rx_buffer_full;
        logic idle;
        logic overrun;
        logic noise;
        logic framing;
        logic parity_err;
    } rx_flags_t;

    // Line configuration register
    typedef struct packed {
        logic nine_bit;
        logic long_break;
        logic wake_on_address;
        logic one_wire_direction;
        logic rx_source;
        logic loopback_select;
    } mode_t;

    localparam int CTL_W  = $bits(control_two_t);
    localparam int STAT_W = $bits(status_one_t);
    localparam int MODE_W = $bits(mode_t);

    localparam logic [CTL_W-1:0]  CONTROL_TWO_RST = 8'h00;
    localparam logic [STAT_W-1:0] STATUS_ONE_RST  = 8'hC0;
    localparam logic [MODE_W-1:0] MODE_RST        = 6'h00;

    // Character lengths in bit times
    localparam logic [3:0] CHAR_LEN_8   = 4'hA;
    localparam logic [3:0] CHAR_LEN_9   = 4'hB;
    localparam logic [3:0] LONG_EXTRA   = 4'h3;

    // Bit time and its cycle count at 100 MHz
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         BIT_TIME_NS   = 160;
    localparam logic [7:0] BIT_CYCLES    = 8'(BIT_TIME_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_IDLE_CHAR,
        SEQ_BREAK
    } seq_state_t;

endpackage

/* src/tx_sequencer.sv */
// Queued idle and break character generator for the transmit line
`timescale 1ns/1ps
module tx_sequencer
    import uart_ctl_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       bit_tick,
    input  wire logic       data_busy,
    input  wire logic       idle_req,
    input  wire logic       break_rise,
    input  wire logic       break_queue,
    input  wire logic [3:0] char_len,
    output logic            busy,
    output logic            pending,
    output logic            line_level
);

    seq_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic       pend_idle_q, pend_idle_d;
    logic       pend_brk_q, pend_brk_d;
    logic       last_bit;
    logic       can_start;

    assign last_bit   = bit_tick && (cnt_q == char_len - 4'h1);
    assign can_start  = bit_tick && !data_busy;
    assign busy       = (state_q != SEQ_IDLE);
    assign pending    = pend_idle_q || pend_brk_q;
    assign line_level = (state_q != SEQ_BREAK);

    // Next state; a new request in the start cycle stays pending
    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        pend_idle_d = pend_idle_q;
        pend_brk_d  = pend_brk_q;
        case (state_q)
            SEQ_IDLE: begin
                if (can_start && pend_brk_q) begin
                    state_d    = SEQ_BREAK;
                    cnt_d      = 4'h0;
                    pend_brk_d = 1'b0;
                end else if (can_start && pend_idle_q) begin
                    state_d     = SEQ_IDLE_CHAR;
                    cnt_d       = 4'h0;
                    pend_idle_d = 1'b0;
                end
            end
            SEQ_IDLE_CHAR, SEQ_BREAK: begin
                if (bit_tick) begin
                    cnt_d = cnt_q + 4'h1;
                end
                if (last_bit) begin
                    cnt_d = 4'h0;
                    if (state_q == SEQ_BREAK && break_queue) begin
                        state_d = SEQ_BREAK;
                    end else if (pend_brk_q) begin
                        state_d    = SEQ_BREAK;
                        pend_brk_d = 1'b0;
                    end else if (pend_idle_q) begin
                        state_d     = SEQ_IDLE_CHAR;
                        pend_idle_d = 1'b0;
                    end else begin
                        state_d = SEQ_IDLE;
                    end
                end
            end
            default: begin
                state_d = SEQ_IDLE;
                cnt_d   = 4'h0;
            end
        endcase
        // Set wins over the clear of the same cycle
        if (idle_req) begin
            pend_idle_d = 1'b1;
        end
        if (break_rise) begin
            pend_brk_d = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q     <= SEQ_IDLE;
            cnt_q       <= 4'h0;
            pend_idle_q <= 1'b0;
            pend_brk_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            pend_idle_q <= pend_idle_d;
            pend_brk_q  <= pend_brk_d;
        end
    end

    property p_idle_kept;
        @(posedge hclk) disable iff (!hresetn)
        idle_req |=> (pend_idle_q || state_q == SEQ_IDLE_CHAR);
    endproperty
    a_idle_kept: assert property (p_idle_kept)
        else $error("queued idle request lost");

    property p_break_repeat;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == SEQ_BREAK && last_bit && break_queue)
            |=> (state_q == SEQ_BREAK && cnt_q == 4'h0);
    endproperty
    a_break_repeat: assert property (p_break_repeat)
        else $error("break not repeated while break bit held");

    property p_break_end;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == SEQ_BREAK && last_bit && !break_queue
            && !pend_brk_q && !pend_idle_q && !break_rise && !idle_req)
            |=> (state_q == SEQ_IDLE);
    endproperty
    a_break_end: assert property (p_break_end)
        else $error("break did not end after its length");

endmodule

/* src/uart_ctl.sv */
// Control and status registers with pin ownership for the serial port
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module uart_ctl
    import uart_ctl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        tx_buffer_empty,
    input  wire rx_flags_t   rx_flags,
    input  wire logic        tx_data_busy,
    input  wire logic        tx_data_level,
    input  wire logic        rxd_in,
    input  wire logic        txd_in,
    input  wire logic        wake_idle,
    input  wire logic        wake_mark,
    output logic             irq,
    output logic             txd_out,
    output logic             txd_oe,
    output logic             rx_pin_owned,
    output logic             rx_line,
    output logic             tx_enable,
    output logic             rx_enable,
    output mode_t            mode,
    output logic             bit_tick
);

    control_two_t      ctl_q, ctl_d;
    status_one_t       status_q, status_d;
    mode_t             mode_q, mode_d;
    logic              wr_pend_q, wr_pend_d;
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic [31:0]       rdata_q, rdata_d;
    logic [7:0]        div_q, div_d;
    logic              tick_q, tick_d;
    logic              irq_q, irq_d;
    logic              txd_q, txd_d;
    logic              oe_q, oe_d;
    logic              rx_own_q, rx_own_d;
    logic              rx_line_q, rx_line_d;
    logic              tx_en_q, tx_en_d;
    logic              rx_en_q, rx_en_d;
    logic              addr_ok;
    logic              wr_ctl;
    logic              wr_mode;
    logic              tx_on_rise;
    logic              brk_rise;
    logic              wake_hit;
    logic              single_wire;
    logic              seq_busy;
    logic              seq_pending;
    logic              seq_level;
    logic [3:0]        char_len;
    control_two_t      ctl_wdata;

    // Address phase qualifier; only word transfers are expected
    assign addr_ok = hsel && hready && hsize == 3'h2
                     && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign ctl_wdata = control_two_t'(hwdata[CTL_W-1:0]);
    // Control accepts writes whatever the transmitter is doing
    assign wr_ctl  = wr_pend_q && wr_addr_q == ADDR_CONTROL_TWO;
    assign wr_mode = wr_pend_q && wr_addr_q == ADDR_MODE;
    assign tx_on_rise = wr_ctl && ctl_wdata.tx_on && !ctl_q.tx_on;
    assign brk_rise   = wr_ctl && ctl_wdata.break_queue
                        && !ctl_q.break_queue;
    // Wake source chosen by the address-mark select
    assign wake_hit = mode_q.wake_on_address ? wake_mark : wake_idle;
    assign single_wire = mode_q.loopback_select && mode_q.rx_source;

    // Break length grows by three bit times in long mode
    always_comb begin
        char_len = mode_q.nine_bit ? CHAR_LEN_9 : CHAR_LEN_8;
        if (mode_q.long_break) begin
            char_len = char_len + LONG_EXTRA;
        end
    end

    // Bus slave: capture writes, answer reads one cycle later
    always_comb begin
        wr_pend_d = addr_ok && hwrite;
        wr_addr_d = wr_addr_q;
        rdata_d   = rdata_q;
        if (addr_ok) begin
            wr_addr_d = haddr[ADDR_W-1:0];
        end
        if (addr_ok && !hwrite) begin
            // Next values so a read right after a write sees it
            case (haddr[ADDR_W-1:0])
                ADDR_CONTROL_TWO: rdata_d = {24'h000000, ctl_d};
                ADDR_STATUS_ONE:  rdata_d = {24'h000000, status_q};
                ADDR_MODE:        rdata_d = {26'h0000000, mode_d};
                default:          rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            rdata_q   <= 32'h00000000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q   <= rdata_d;
        end
    end

    // Zero wait states, response always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = rdata_q;

    // Control and mode registers; status has no write path at all
    always_comb begin
        ctl_d  = ctl_q;
        mode_d = mode_q;
        if (ctl_q.rx_standby && wake_hit) begin
            ctl_d.rx_standby = 1'b0;
        end
        // A software write wins over the wakeup clear
        if (wr_ctl) begin
            ctl_d = ctl_wdata;
        end
        if (wr_mode) begin
            mode_d = mode_t'(hwdata[MODE_W-1:0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q  <= control_two_t'(CONTROL_TWO_RST);
            mode_q <= mode_t'(MODE_RST);
        end else begin
            ctl_q  <= ctl_d;
            mode_q <= mode_d;
        end
    end

    // Status snapshot; done flag is idle transmitter with empty buffer
    always_comb begin
        status_d                 = status_q;
        status_d.tx_buffer_empty = tx_buffer_empty;
        status_d.tx_done         = tx_buffer_empty && !tx_data_busy
                                   && !seq_busy && !seq_pending;
        status_d.rx_buffer_full  = rx_flags.rx_buffer_full;
        status_d.idle            = rx_flags.idle;
        status_d.overrun         = rx_flags.overrun;
        status_d.noise           = rx_flags.noise;
        status_d.framing         = rx_flags.framing;
        status_d.parity_err      = rx_flags.parity_err;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= status_one_t'(STATUS_ONE_RST);
        end else begin
            status_q <= status_d;
        end
    end

    // Bit-time divider; a stand-in for the baud generator outside
    always_comb begin
        div_d  = div_q + 8'h01;
        tick_d = 1'b0;
        if (div_q == BIT_CYCLES - 8'h01) begin
            div_d  = 8'h00;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    tx_sequencer u_seq (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .bit_tick    (tick_q),
        .data_busy   (tx_data_busy),
        .idle_req    (tx_on_rise),
        .break_rise  (brk_rise),
        .break_queue (ctl_q.break_queue),
        .char_len    (char_len),
        .busy        (seq_busy),
        .pending     (seq_pending),
        .line_level  (seq_level)
    );

    // Interrupt request and pin steering
    always_comb begin
        irq_d = (ctl_q.tx_empty_irq_on   && status_q.tx_buffer_empty)
             || (ctl_q.tx_done_irq_on    && status_q.tx_done)
             || (ctl_q.rx_full_irq_on    && status_q.rx_buffer_full)
             || (ctl_q.quiet_line_irq_on && status_q.idle);
        tx_en_d = ctl_q.tx_on;
        // Pin kept until queued work drains after disable
        oe_d = ctl_q.tx_on || tx_data_busy
               || seq_busy || seq_pending;
        if (single_wire && !mode_q.one_wire_direction) begin
            oe_d = 1'b0;
        end
        txd_d = seq_busy ? seq_level : tx_data_level;
        // Receive pin released when off or in any loop mode
        rx_en_d  = ctl_q.rx_on && !ctl_q.rx_standby;
        rx_own_d = ctl_q.rx_on && !mode_q.loopback_select;
        if (!mode_q.loopback_select) begin
            rx_line_d = rxd_in;
        end else if (mode_q.rx_source) begin
            rx_line_d = oe_q ? txd_q : txd_in;
        end else begin
            rx_line_d = txd_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q     <= 1'b0;
            tx_en_q   <= 1'b0;
            oe_q      <= 1'b0;
            txd_q     <= 1'b1;
            rx_en_q   <= 1'b0;
            rx_own_q  <= 1'b0;
            rx_line_q <= 1'b1;
        end else begin
            irq_q     <= irq_d;
            tx_en_q   <= tx_en_d;
            oe_q      <= oe_d;
            txd_q     <= txd_d;
            rx_en_q   <= rx_en_d;
            rx_own_q  <= rx_own_d;
            rx_line_q <= rx_line_d;
        end
    end

    assign irq          = irq_q;
    assign txd_out      = txd_q;
    assign txd_oe       = oe_q;
    assign rx_pin_owned = rx_own_q;
    assign rx_line      = rx_line_q;
    assign tx_enable    = tx_en_q;
    assign rx_enable    = rx_en_q;
    assign mode         = mode_q;
    assign bit_tick     = tick_q;

    property p_irq_tx_empty;
        @(posedge hclk) disable iff (!hresetn)
        (ctl_q.tx_empty_irq_on && status_q.tx_buffer_empty) |=> irq_q;
    endproperty
    a_irq_tx_empty: assert property (p_irq_tx_empty)
        else $error("missing irq for empty transmit buffer");

    property p_irq_tx_done;
        @(posedge hclk) disable iff (!hresetn)
        (ctl_q.tx_done_irq_on && status_q.tx_done) |=> irq_q;
    endproperty
    a_irq_tx_done: assert property (p_irq_tx_done)
        else $error("missing irq for transmit done");

    property p_irq_rx_full;
        @(posedge hclk) disable iff (!hresetn)
        (ctl_q.rx_full_irq_on && status_q.rx_buffer_full) |=> irq_q;
    endproperty
    a_irq_rx_full: assert property (p_irq_rx_full)
        else $error("missing irq for full receive buffer");

    property p_irq_idle;
        @(posedge hclk) disable iff (!hresetn)
        (ctl_q.quiet_line_irq_on && status_q.idle) |=> irq_q;
    endproperty
    a_irq_idle: assert property (p_irq_idle)
        else $error("missing irq for idle line");

    property p_irq_quiet;
        @(posedge hclk) disable iff (!hresetn)
        ((ctl_q & 8'hF0) == 8'h00) |=> !irq_q;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq raised with all enables clear");

    property p_tx_pin_held;
        @(posedge hclk) disable iff (!hresetn)
        ($fell(ctl_q.tx_on) && seq_pending && !single_wire) |=> oe_q;
    endproperty
    a_tx_pin_held: assert property (p_tx_pin_held)
        else $error("transmit pin released with work queued");

    property p_tx_pin_own;
        @(posedge hclk) disable iff (!hresetn)
        (ctl_q.tx_on && !single_wire) |=> (oe_q && tx_en_q);
    endproperty
    a_tx_pin_own: assert property (p_tx_pin_own)
        else $error("transmitter enabled but pin not driven");

    property p_rx_release;
        @(posedge hclk) disable iff (!hresetn)
        (!ctl_q.rx_on || mode_q.loopback_select) |=> !rx_own_q;
    endproperty
    a_rx_release: assert property (p_rx_release)
        else $error("receive pin held while off or looped");

    property p_standby_wake;
        @(posedge hclk) disable iff (!hresetn)
        (ctl_q.rx_standby && wake_hit && !wr_ctl) |=> !ctl_q.rx_standby;
    endproperty
    a_standby_wake: assert property (p_standby_wake)
        else $error("standby not cleared on wakeup");

    property p_status_ro;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_q && wr_addr_q == ADDR_STATUS_ONE)
            |=> (ctl_q == $past(ctl_q) || $past(wake_hit));
    endproperty
    a_status_ro: assert property (p_status_ro)
        else $error("status write changed control state");

    property p_done_busy;
        @(posedge hclk) disable iff (!hresetn)
        seq_busy |=> !status_q.tx_done;
    endproperty
    a_done_busy: assert property (p_done_busy)
        else $error("done flag set while a break or idle is sent");

endmodule

/* tb/far_uart.sv */
// Remote serial transceiver model facing the transmit and receive pins
`timescale 1ns/1ps
module far_uart (
    input  wire logic  hclk,
    input  wire logic  txd_out,
    input  wire logic  txd_oe,
    input  wire logic  clr,
    output logic       rxd_in,
    output logic       txd_in,
    output logic [7:0] brk_len,
    output logic [3:0] brk_n
);
    logic [11:0] low_n;
    logic        last_out = 1'b1;
    // We only listen, so our sending line rests at mark
    assign rxd_in = 1'b1;
    // Released shared line shows the inverse of the last driven level
    assign txd_in = txd_oe ? txd_out : !last_out;
    // Each driven low run is one break, rounded to 16-cycle bit times
    always @(posedge hclk) begin
        if (txd_oe) last_out <= txd_out;
        if (clr) begin
            low_n   <= 12'h000;
            brk_n   <= 4'h0;
            brk_len <= 8'h00;
        end else if (txd_oe && !txd_out) begin
            low_n <= low_n + 12'h001;
        end else if (low_n != 12'h000) begin
            brk_len <= 8'((low_n + 12'h008) / 12'h010);
            brk_n   <= brk_n + 4'h1;
            low_n   <= 12'h000;
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the serial control and status block
`timescale 1ns/1ps
module tb_top;
    import uart_ctl_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic        tbe = 1'b1;
    rx_flags_t   rxf = '0;
    logic        wk_idle = 1'b0;
    logic        wk_mark = 1'b0;
    logic        clr = 1'b1;
    logic        rd_v = 1'b0;
    logic        pin_v = 1'b0;
    logic        hready, irq, txd_out, txd_oe, rx_own, rx_en, rxd_in, txd_in;
    logic        hresp, rx_line, tx_en;
    logic [31:0] hrdata;
    logic [7:0]  brk_len;
    logic [3:0]  brk_n;
    logic [31:0] qr[$];
    logic [31:0] qp[$];
    int          n_errors = 0;
    int          total_checks = 0;
    wire  [15:0] pins = {tx_en, rx_line, hresp,
                         brk_n == 4'h1 || brk_n == 4'h2,
                         brk_len, irq, txd_oe, rx_own, rx_en};
    always #5 hclk = ~hclk;
    uart_ctl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .tx_buffer_empty(tbe), .rx_flags(rxf), .tx_data_busy(1'b0),
        .tx_data_level(1'b1), .rxd_in(rxd_in), .txd_in(txd_in),
        .wake_idle(wk_idle), .wake_mark(wk_mark), .irq(irq),
        .txd_out(txd_out), .txd_oe(txd_oe), .rx_pin_owned(rx_own),
        .rx_line(rx_line), .tx_enable(tx_en), .rx_enable(rx_en), .mode(),
        .bit_tick());
    far_uart far (.hclk(hclk), .txd_out(txd_out), .txd_oe(txd_oe), .clr(clr),
        .rxd_in(rxd_in), .txd_in(txd_in), .brk_len(brk_len), .brk_n(brk_n));
    task automatic cmp(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Single word transfer; held until hready is seen high each phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_v   <= !w;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_v   <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        qr.push_back(e);
        bus(1'b0, a, 32'h00000000);
    endtask
    // Extra idle edge so the strobe is never raised twice in one step
    task automatic expect_pin(input logic [15:0] m, input logic [15:0] e);
        qp.push_back({m, e});
        pin_v <= 1'b1;
        @(posedge hclk);
        pin_v <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic pulse(input logic m);
        if (m) wk_mark <= 1'b1;
        else wk_idle <= 1'b1;
        @(posedge hclk);
        wk_mark <= 1'b0;
        wk_idle <= 1'b0;
        @(posedge hclk);
    endtask
    // Oldest note against what the outputs show now
    always @(posedge hclk) begin
        logic [31:0] e;
        if (rd_v) cmp("hrdata", qr.pop_front(), hrdata);
        if (pin_v) begin
            e = qp.pop_front();
            cmp("pins", 32'(e[15:0]), 32'(pins & e[31:16]));
        end
    end
    // Whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        give_verdict();
    end
    initial begin
        int i;
        int j;
        logic [3:0] fl;
        logic [7:0] bl;
        void'($urandom(32'h3F84DB61));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        clr     <= 1'b0;
        @(posedge hclk);
        rd(ADDR_CONTROL_TWO, 32'h00000000);
        rd(ADDR_STATUS_ONE, 32'h000000C0);
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            tbe <= 1'($urandom);
            rxf <= 6'($urandom);
            wr(ADDR_CONTROL_TWO, 32'h00000080 >> (i % 4));
            repeat (3) @(posedge hclk);
            fl = {tbe, tbe, rxf.rx_buffer_full, rxf.idle} >> (3 - i % 4);
            expect_pin(16'hE00F, {12'h400,fl[0],3'h0});
            rd(ADDR_STATUS_ONE, {24'h000000, tbe, tbe, rxf});
        end
        tbe <= 1'b1;
        rxf <= '0;
        wr(ADDR_STATUS_ONE, 32'h00000000);
        rd(ADDR_STATUS_ONE, 32'h000000C0);
        rd(8'h0C, 32'h00000000);
        $display("interrupt test done");
        wr(ADDR_CONTROL_TWO, 32'h0000000C);
        rd(ADDR_CONTROL_TWO, 32'h0000000C);
        expect_pin(16'hE00F, 16'hC007);
        // Loopback, then single wire receiving, then single wire driving
        for (i = 0; i < 3; i++) begin
            wr(ADDR_MODE, 32'h00000007 >> (2 - i));
            repeat (3) @(posedge hclk);
            fl[0] = (i != 1);
            expect_pin(16'hC007, {1'b1, fl[0], 11'h000, fl[0], 2'h1});
        end
        $display("pin test done");
        for (i = 0; i < 2; i++) begin
            wr(ADDR_MODE, 32'(i << 4));
            clr <= 1'b1;
            @(posedge hclk);
            clr <= 1'b0;
            wr(ADDR_CONTROL_TWO, 32'h0000000D);
            wr(ADDR_CONTROL_TWO, 32'h00000004);
            expect_pin(16'h0004, 16'h0004);
            for (j = 0; j < 3000 && txd_oe !== 1'b0; j++) @(posedge hclk);
            @(posedge hclk);
            bl = 8'(CHAR_LEN_8) + (i ? 8'(LONG_EXTRA) : 8'h00);
            expect_pin(16'hBFF4, {4'h1, bl, 4'h0});
        end
        $display("break test done");
        for (i = 0; i < 2; i++) begin
            wr(ADDR_MODE, 32'(i << 3));
            wr(ADDR_CONTROL_TWO, 32'h00000006);
            repeat (2) @(posedge hclk);
            expect_pin(16'h8001, 16'h0000);
            pulse(i == 0);
            rd(ADDR_CONTROL_TWO, 32'h00000006);
            pulse(i == 1);
            rd(ADDR_CONTROL_TWO, 32'h00000004);
        end
        $display("standby test done");
        give_verdict();
    end
endmodule
